// ### src/dma_pkg.sv
// Contract
// [RULE_01] Status bit shows card transfer in progress.
// [RULE_02] Gather bit selects block or table mode.
// [RULE_03] Soft reset clears state machine and pointers.
// [RULE_04] Soft reset keeps control bits; self clears.
// [RULE_05] Disabled engine ignores requests, master idle.
// [RULE_06] Bus abort clears engine enable by hardware.
// [RULE_07] Full 32-bit start pointer for block mode.
// [RULE_08] Gather mode: pointer addresses first descriptor.
// [RULE_09] Software keeps start pointer word aligned.
// [RULE_10] Software tables cover the card sector count.
// [RULE_11] Last descriptor marked; walk stops there.
// [RULE_12] Descriptor: base word, count low, mark top.
// [RULE_13] Read-only 26-bit remaining byte counter decrements.
// [RULE_14] Counter reads zero unless transfer busy.
// [RULE_15] Table end before count done sets flag.
// [RULE_16] Bus error stops transfer, flags, returns idle.
// [RULE_17] Shared 2048-byte buffer in four sections.
// [RULE_18] Sector is 512 bytes; pointer steps four.
// [RULE_19] Soft reset clears within four cycles; busy zero.
package dma_pkg;
   localparam logic [31:0] CSR_ADDR = 32'hb000c800;
   localparam logic [31:0] PTR_ADDR = 32'hb000c808;
   localparam logic [31:0] CNT_ADDR = 32'hb000c80c;
   localparam logic [31:0] IEN_ADDR = 32'hb000c810;
   localparam logic [31:0] IST_ADDR = 32'hb000c814;
   localparam logic [31:0] ICLR_ADDR = 32'hb000c818;
   localparam logic [31:0] BUF_BASE = 32'hb000c000;
   localparam int BUF_TOP = 11;
   localparam int EN_BIT = 0;
   localparam int SRST_BIT = 1;
   localparam int GATHER_BIT = 3;
   localparam int BUSY_BIT = 9;
   localparam int ABORT_BIT = 0;
   localparam int EARLY_FLAG_BIT = 1;
   localparam logic [1:0] IEN_RESET = 2'h1;
   localparam int CNT_W = 26;
   localparam int SEC_W = 16;
   localparam int TABLE_END_BIT = 31;
   localparam logic [8:0] SECTOR_PAD = 9'h000;
   localparam logic [31:0] ADDR_STEP = 32'h00000004;
   localparam logic [CNT_W-1:0] CNT_STEP = 26'h0000004;
   localparam logic [2:0] SRST_CYCLES = 3'h3;
   localparam int BUF_WORDS = 512;
   localparam int BUF_AW = 9;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic we;
   } mem_cmd_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic ack;
      logic err;
   } mem_rsp_t;

   typedef enum logic [1:0] {ST_IDLE, ST_DESC_ADDR, ST_DESC_CNT, ST_MOVE} state_t;
endpackage

// ### src/dma_shared_buffer.sv
`timescale 1ns/100ps
module dma_shared_buffer
   import dma_pkg::*;
#(
   parameter int WORDS = BUF_WORDS,
   parameter int AW = BUF_AW
) (
   input wire logic clk,
   input wire logic a_we,
   input wire logic [AW-1:0] a_idx,
   input wire logic [31:0] a_wdata,
   output logic [31:0] a_rdata,
   input wire logic b_we,
   input wire logic [AW-1:0] b_idx,
   input wire logic [31:0] b_wdata,
   output logic [31:0] b_rdata
);
   // ****************************************
   // Storage
   // ****************************************
   logic [31:0] mem [WORDS];

   // The engine port wins a clash; software only writes while the engine is idle.
   always_ff @(posedge clk) begin
      if (a_we) begin
         mem[a_idx] <= a_wdata;
      end else if (b_we) begin
         mem[b_idx] <= b_wdata;
      end
   end

   assign a_rdata = mem[a_idx];
   assign b_rdata = mem[b_idx];
endmodule

// ### src/sg_dma_engine.sv
`timescale 1ns/100ps
module sg_dma_engine
   import dma_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic card_start,
   input wire logic card_to_mem,
   input wire logic [SEC_W-1:0] card_sectors,
   output logic card_done,
   output logic card_abort,
   output logic card_early_end,
   output logic mem_req,
   output mem_cmd_t mem_cmd,
   input wire mem_rsp_t mem_rsp,
   output logic irq
);
   // ****************************************
   // Declarations
   // ****************************************
   logic en_reg, gather_reg, busy_reg, dir_reg, table_end_reg;
   logic [31:0] ptr_reg, cur_reg, desc_reg;
   logic [2:0] srst_cnt_reg;
   state_t state_reg;
   logic [CNT_W-1:0] remain_reg, seg_reg, cnt_view, total;
   logic [BUF_AW-1:0] widx_reg;
   logic [1:0] status_reg, ien_reg, status_next, events;
   logic mem_req_reg, pready_reg, pslverr_reg, irq_reg;
   logic done_reg, abort_reg, early_reg;
   mem_cmd_t mem_cmd_reg;
   logic [31:0] prdata_reg, rd_data, buf_a_rdata, buf_b_rdata;
   logic unmapped, wr_acc, buf_hit, csr_wr, srst_active, halt;
   logic ack, err, last_word, seg_last, cnt_zero;
   logic fin_ok, fin_early, abort_ev, buf_a_we;
   logic [CNT_W-1:0] desc_len;

   assign srst_active = srst_cnt_reg != 3'h0;
   assign halt = srst_active || !en_reg; // RULE_05
   assign ack = mem_req_reg && mem_rsp.ack;
   assign err = mem_req_reg && mem_rsp.err;
   assign last_word = remain_reg == CNT_STEP;
   assign seg_last = seg_reg == CNT_STEP;
   assign desc_len = CNT_W'({mem_rsp.rdata[SEC_W-1:0], SECTOR_PAD}); // RULE_12 RULE_18
   assign cnt_zero = mem_rsp.rdata[SEC_W-1:0] == '0;
   assign total = CNT_W'({card_sectors, SECTOR_PAD}); // RULE_18
   assign cnt_view = busy_reg ? remain_reg : '0; // RULE_14

   // ****************************************
   // Transfer events
   // ****************************************
   always_comb begin
      fin_ok = ack && !halt && state_reg == ST_MOVE && last_word;
      fin_early = 1'b0;
      if (ack && !halt && gather_reg) begin
         if (state_reg == ST_MOVE && !last_word && seg_last && table_end_reg) begin
            fin_early = 1'b1; // RULE_15 RULE_11
         end
         if (state_reg == ST_DESC_CNT && cnt_zero && mem_rsp.rdata[TABLE_END_BIT]) begin
            fin_early = 1'b1; // RULE_15
         end
      end
      abort_ev = err && !halt && busy_reg; // RULE_16
   end

   assign events = {fin_early, abort_ev};

   // ****************************************
   // Engine state machine
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         dir_reg <= 1'b0;
         table_end_reg <= 1'b0;
         remain_reg <= '0;
         seg_reg <= '0;
         cur_reg <= '0;
         desc_reg <= '0;
         widx_reg <= '0;
      end else if (halt) begin
         state_reg <= ST_IDLE; // RULE_03 RULE_05 RULE_19
         busy_reg <= 1'b0;
         table_end_reg <= 1'b0;
         remain_reg <= '0;
         seg_reg <= '0;
         cur_reg <= '0;
         desc_reg <= '0;
         widx_reg <= '0;
      end else if (abort_ev || fin_ok || fin_early) begin
         state_reg <= ST_IDLE; // RULE_16
         busy_reg <= 1'b0;
         remain_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (card_start) begin
                  busy_reg <= 1'b1; // RULE_01
                  dir_reg <= card_to_mem;
                  remain_reg <= total;
                  table_end_reg <= 1'b0;
                  widx_reg <= '0;
                  if (gather_reg) begin
                     desc_reg <= ptr_reg; // RULE_02 RULE_08
                     state_reg <= ST_DESC_ADDR;
                  end else begin
                     cur_reg <= ptr_reg; // RULE_02 RULE_07
                     seg_reg <= total;
                     state_reg <= ST_MOVE;
                  end
               end
            end
            ST_DESC_ADDR: begin
               if (ack) begin
                  cur_reg <= mem_rsp.rdata; // RULE_12
                  desc_reg <= desc_reg + ADDR_STEP;
                  state_reg <= ST_DESC_CNT;
               end
            end
            ST_DESC_CNT: begin
               if (ack) begin
                  seg_reg <= desc_len; // RULE_12
                  table_end_reg <= mem_rsp.rdata[TABLE_END_BIT];
                  desc_reg <= desc_reg + ADDR_STEP;
                  state_reg <= cnt_zero ? ST_DESC_ADDR : ST_MOVE;
               end
            end
            ST_MOVE: begin
               if (ack) begin
                  cur_reg <= cur_reg + ADDR_STEP; // RULE_18
                  seg_reg <= seg_reg - CNT_STEP;
                  remain_reg <= remain_reg - CNT_STEP; // RULE_13
                  widx_reg <= widx_reg + 1'b1; // RULE_17
                  if (seg_last) begin
                     state_reg <= ST_DESC_ADDR; // RULE_11
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Bus master
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req_reg <= 1'b0;
         mem_cmd_reg <= '0;
      end else if (halt || ack || err) begin
         mem_req_reg <= 1'b0; // RULE_05
      end else if (busy_reg && !mem_req_reg && state_reg != ST_IDLE) begin
         mem_req_reg <= 1'b1;
         mem_cmd_reg.addr <= state_reg == ST_MOVE ? cur_reg : desc_reg;
         mem_cmd_reg.we <= state_reg == ST_MOVE && dir_reg;
         mem_cmd_reg.wdata <= buf_a_rdata;
      end
   end

   // The four 512-byte sections are the top two bits of the word index, so a
   // multi-sector run rotates through them while the card drains the others.
   assign buf_a_we = ack && !halt && state_reg == ST_MOVE && !dir_reg; // RULE_17

   dma_shared_buffer #(
      .WORDS(BUF_WORDS),
      .AW(BUF_AW)
   ) u_buf (
      .clk(pclk),
      .a_we(buf_a_we),
      .a_idx(widx_reg),
      .a_wdata(mem_rsp.rdata),
      .a_rdata(buf_a_rdata),
      .b_we(wr_acc && buf_hit && !busy_reg),
      .b_idx(paddr[BUF_TOP-1:2]),
      .b_wdata(pwdata),
      .b_rdata(buf_b_rdata)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         abort_reg <= 1'b0;
         early_reg <= 1'b0;
      end else begin
         done_reg <= fin_ok;
         abort_reg <= abort_ev; // RULE_16
         early_reg <= fin_early;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   assign wr_acc = psel && penable && pready_reg && pwrite;
   assign csr_wr = wr_acc && paddr == CSR_ADDR;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= 1'b0;
         gather_reg <= 1'b0;
         srst_cnt_reg <= 3'h0;
         ptr_reg <= '0;
         ien_reg <= IEN_RESET;
      end else begin
         if (abort_ev) begin
            en_reg <= 1'b0; // RULE_06
         end else if (csr_wr) begin
            en_reg <= pwdata[EN_BIT];
         end
         if (csr_wr) begin
            gather_reg <= pwdata[GATHER_BIT];
         end
         if (csr_wr && pwdata[SRST_BIT]) begin
            srst_cnt_reg <= SRST_CYCLES; // RULE_03 RULE_04
         end else if (srst_active) begin
            srst_cnt_reg <= srst_cnt_reg - 3'h1; // RULE_19
         end
         if (wr_acc && paddr == PTR_ADDR) begin
            ptr_reg <= pwdata; // RULE_07
         end
         if (wr_acc && paddr == IEN_ADDR) begin
            ien_reg <= pwdata[1:0];
         end
      end
   end

   // A flag raised in the cycle of its clear survives the clear.
   always_comb begin
      status_next = status_reg;
      if (wr_acc && paddr == ICLR_ADDR) begin
         status_next = status_reg & ~pwdata[1:0];
      end
      status_next = status_next | events; // RULE_15 RULE_16
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 2'h0;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg <= |(status_next & ien_reg);
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   assign buf_hit = paddr[31:BUF_TOP] == BUF_BASE[31:BUF_TOP];

   always_comb begin
      rd_data = '0;
      unmapped = 1'b0;
      if (buf_hit) begin
         rd_data = busy_reg ? '0 : buf_b_rdata;
      end else begin
         case (paddr)
            CSR_ADDR: begin
               rd_data[EN_BIT] = en_reg;
               rd_data[SRST_BIT] = srst_active;
               rd_data[GATHER_BIT] = gather_reg;
               rd_data[BUSY_BIT] = busy_reg; // RULE_01
            end
            PTR_ADDR: rd_data = ptr_reg;
            CNT_ADDR: rd_data[CNT_W-1:0] = cnt_view; // RULE_13 RULE_14
            IEN_ADDR: rd_data[1:0] = ien_reg;
            IST_ADDR: rd_data[1:0] = status_reg;
            ICLR_ADDR: rd_data = '0;
            default: unmapped = 1'b1;
         endcase
      end
   end

   // One wait state lets every answer leave from a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
         pslverr_reg <= psel && penable && !pready_reg && unmapped;
         prdata_reg <= (psel && penable && !pready_reg && !pwrite) ? rd_data : '0;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mem_req = mem_req_reg;
   assign mem_cmd = mem_cmd_reg;
   assign card_done = done_reg;
   assign card_abort = abort_reg;
   assign card_early_end = early_reg;
   assign irq = irq_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_master_idle_off: assert property (!en_reg |=> !mem_req_reg) // RULE_05
      else $error("master active while disabled");
   a_start_ignored: assert property (card_start && halt && !busy_reg |=> !busy_reg) // RULE_05
      else $error("request taken while disabled");
   a_abort_clears_en: assert property (abort_ev |=> !en_reg && !busy_reg && status_reg[ABORT_BIT]) // RULE_06
      else $error("abort did not stop engine");
   a_abort_pulse: assert property (abort_ev |=> card_abort ##1 !card_abort) // RULE_16
      else $error("abort pulse wrong");
   a_srst_self_clear: assert property ($rose(srst_active) |-> srst_active[*3] ##1 !srst_active) // RULE_19
      else $error("soft reset length wrong");
   a_srst_keeps_ctrl: assert property (srst_active && !wr_acc
      |=> $stable(ptr_reg) && $stable(en_reg) && $stable(gather_reg) && !busy_reg) // RULE_04
      else $error("soft reset disturbed control");
   a_count_idle_zero: assert property (psel && penable && !pready_reg && !pwrite
      && paddr == CNT_ADDR && !busy_reg |=> prdata == '0) // RULE_14
      else $error("count visible while idle");
   a_count_step: assert property (ack && !halt && state_reg == ST_MOVE && !last_word && !fin_early
      |=> remain_reg == $past(remain_reg) - CNT_STEP && cur_reg == $past(cur_reg) + ADDR_STEP) // RULE_13
      else $error("count or pointer step wrong");
   a_block_start: assert property (card_start && !halt && !busy_reg && !gather_reg
      |=> state_reg == ST_MOVE && cur_reg == $past(ptr_reg) && remain_reg == $past(total)) // RULE_07
      else $error("block start wrong");
   a_table_start: assert property (card_start && !halt && !busy_reg && gather_reg
      |=> state_reg == ST_DESC_ADDR && desc_reg == $past(ptr_reg)) // RULE_08
      else $error("table start wrong");
   a_desc_decode: assert property (ack && !halt && state_reg == ST_DESC_CNT && !cnt_zero
      |=> seg_reg == $past(desc_len) && table_end_reg == $past(mem_rsp.rdata[TABLE_END_BIT]))
      // RULE_12
      else $error("descriptor decode wrong");
   a_early_flag: assert property (fin_early |=> status_reg[EARLY_FLAG_BIT] && state_reg == ST_IDLE)
      // RULE_15
      else $error("early table end not flagged");
   a_busy_state: assert property (busy_reg |-> state_reg != ST_IDLE) // RULE_01
      else $error("busy without transfer");

   c_block_done: cover property (!gather_reg && fin_ok);
   c_table_done: cover property (gather_reg && fin_ok);
   c_early_end: cover property (fin_early);
   c_abort: cover property (abort_ev);
endmodule

// ### verif/mem_model.sv
`timescale 1ns/100ps
module mem_model
   import dma_pkg::*;
#(
   parameter logic [31:0] PAT = 32'h3c3ca5a5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire mem_cmd_t mem_cmd,
   output mem_rsp_t mem_rsp,
   input wire logic hold,
   input wire logic [3:0] lag,
   input wire logic [31:0] err_addr
);
   // ****************
   // System memory
   // ****************
   // Unwritten words read as their address mixed with a pattern, so every beat is checkable.
   logic [31:0] words [logic [31:0]];
   int beats;
   logic [31:0] last_addr;
   logic [3:0] cnt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rsp <= '0;
         cnt <= 4'h0;
         beats <= 0;
         last_addr <= 32'h0;
      end else begin
         mem_rsp.ack <= 1'b0;
         mem_rsp.err <= 1'b0;
         // An idle bus inverts the last answer every cycle, so a stale copy shows only on every other cycle.
         mem_rsp.rdata <= ~mem_rsp.rdata;
         if (!mem_req) begin
            cnt <= 4'h0;
         end else if (!hold && !mem_rsp.ack && !mem_rsp.err) begin
            if (cnt < lag) begin
               cnt <= cnt + 4'h1;
            end else begin
               cnt <= 4'h0;
               beats <= beats + 1;
               last_addr <= mem_cmd.addr;
               if (mem_cmd.addr == err_addr) begin
                  mem_rsp.err <= 1'b1;
               end else begin
                  mem_rsp.ack <= 1'b1;
               end
               if (words.exists(mem_cmd.addr)) begin
                  mem_rsp.rdata <= words[mem_cmd.addr];
               end else begin
                  mem_rsp.rdata <= mem_cmd.addr ^ PAT;
               end
               if (mem_cmd.we) begin
                  words[mem_cmd.addr] = mem_cmd.wdata;
               end
            end
         end
      end
   end
endmodule

// ### verif/scatter_gather_dma_engine_tb_top.sv
`timescale 1ns/100ps
module scatter_gather_dma_engine_tb_top
   import dma_pkg::*;
;
   localparam logic [31:0] PAT = 32'h3c3ca5a5;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic card_start, card_to_mem, card_done, card_abort, card_early_end, mem_req, hold;
   logic [31:0] paddr, pwdata, prdata, err_addr, ptr, prev, tab, a0, a1;
   logic [SEC_W-1:0] card_sectors;
   logic [3:0] lag;
   mem_cmd_t mem_cmd;
   mem_rsp_t mem_rsp;
   int failures, cmp_count, base;
   logic [32:0] rd_q[$];
   logic [2:0] ev_q[$];

   sg_dma_engine i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .card_start(card_start), .card_to_mem(card_to_mem),
      .card_sectors(card_sectors), .card_done(card_done), .card_abort(card_abort),
      .card_early_end(card_early_end), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .mem_rsp(mem_rsp), .irq(irq));
   mem_model #(.PAT(PAT)) i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .hold(hold), .lag(lag), .err_addr(err_addr));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // ****************
   // Shared tasks
   // ****************
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      check(n < 20, 1'b1, "bus answer");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic err = 1'b0);
      rd_q.push_back({err, exp});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic start(input logic dir, input logic [SEC_W-1:0] s, input logic [2:0] ev);
      if (ev != 3'h0) begin
         ev_q.push_back(ev);
      end
      @(posedge pclk);
      card_start <= 1'b1;
      card_to_mem <= dir;
      card_sectors <= s;
      @(posedge pclk);
      card_start <= 1'b0;
   endtask

   task automatic wait_ev();
      int n;
      n = 0;
      while (ev_q.size() != 0 && n < 4000) begin
         n++;
         @(posedge pclk);
      end
      check(n < 4000, 1'b1, "transfer end");
   endtask

   task automatic settle_irq(input logic exp);
      repeat (2) @(posedge pclk);
      check(irq, exp, "interrupt line");
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************
   // Result watcher
   // ****************
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (rd_q.size() == 0) check(1'b1, 1'b0, "unexpected read");
         else check({pslverr, prdata}, rd_q.pop_front(), "read data");
      end
      if ((card_done | card_abort | card_early_end) === 1'b1) begin
         if (ev_q.size() == 0) check(1'b1, 1'b0, "unexpected end pulse");
         else check({card_done, card_abort, card_early_end}, ev_q.pop_front(), "end pulse");
      end
   end

   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      report_and_stop();
   end

   // ****************
   // Main sequence
   // ****************
   initial begin
      {psel, penable, pwrite, card_start, card_to_mem, hold} = 6'h00;
      {paddr, pwdata} = 64'h0;
      card_sectors = '0;
      lag = 4'h0;
      err_addr = 32'hffffffff;
      failures = 0;
      cmp_count = 0;
      presetn = 1'b0;
      void'($urandom(32'h522c9224));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(CSR_ADDR, 32'h0);
      rd(PTR_ADDR, 32'h0);
      rd(CNT_ADDR, 32'h0);
      rd(IEN_ADDR, {30'h0, IEN_RESET});
      rd(IST_ADDR, 32'h0);
      rd(CSR_ADDR + 32'h4, 32'h0, 1'b1);
      wr(CNT_ADDR, 32'hffffffff);
      rd(CNT_ADDR, 32'h0);
      ptr = $urandom & 32'h00fffffc;
      wr(PTR_ADDR, ptr);
      rd(PTR_ADDR, ptr);
      $display("test registers done");
      start(1'b0, 16'h1, 3'h0);
      repeat (20) begin
         @(posedge pclk);
         check(mem_req, 1'b0, "master idle");
      end
      rd(CSR_ADDR, 32'h0);
      $display("test disabled done");
      hold <= 1'b1;
      wr(CSR_ADDR, 32'h1);
      start(1'b0, 16'h3, 3'h0);
      repeat (4) @(posedge pclk);
      rd(CNT_ADDR, 32'h600);
      rd(CSR_ADDR, 32'h201);
      wr(CSR_ADDR, 32'h3);
      repeat (4) @(posedge pclk);
      rd(CSR_ADDR, 32'h1);
      rd(CNT_ADDR, 32'h0);
      hold <= 1'b0;
      repeat (20) @(posedge pclk);
      check(mem_req, 1'b0, "dropped request");
      $display("test soft reset done");
      for (int d = 0; d < 2; d++) begin
         lag <= 4'($urandom_range(3));
         prev = ptr;
         ptr = $urandom & 32'h00fffffc;
         wr(PTR_ADDR, ptr);
         base = i_mem.beats;
         start(d[0], 16'h2, 3'h4);
         wait_ev();
         check(i_mem.beats - base, 256, "beats");
         check(i_mem.last_addr, ptr + 32'h3fc, "last address");
         rd(CNT_ADDR, 32'h0);
         if (d == 0) rd(BUF_BASE, ptr ^ PAT);
         else check(i_mem.words[ptr], prev ^ PAT, "written word");
      end
      $display("test block done");
      tab = 32'h01000000 | ($urandom & 32'h0000fff0);
      a0 = 32'h02000000 | ($urandom & 32'h000ffffc);
      a1 = 32'h03000000 | ($urandom & 32'h000ffffc);
      i_mem.words[tab] = a0;
      i_mem.words[tab + 32'h4] = 32'h00000001;
      i_mem.words[tab + 32'h8] = a1;
      i_mem.words[tab + 32'hc] = 32'h80000001;
      wr(PTR_ADDR, tab);
      wr(CSR_ADDR, 32'h9);
      base = i_mem.beats;
      start(1'b0, 16'h2, 3'h4);
      wait_ev();
      check(i_mem.beats - base, 260, "gather beats");
      check(i_mem.last_addr, a1 + 32'h1fc, "gather last");
      $display("test gather done");
      i_mem.words[tab + 32'h4] = 32'h80000001;
      wr(IEN_ADDR, 32'h3);
      start(1'b0, 16'h2, 3'h1);
      wait_ev();
      settle_irq(1'b1);
      rd(IST_ADDR, 32'h2);
      wr(ICLR_ADDR, 32'h2);
      rd(IST_ADDR, 32'h0);
      settle_irq(1'b0);
      $display("test early end done");
      wr(CSR_ADDR, 32'h1);
      err_addr <= tab + 32'h8;
      start(1'b0, 16'h1, 3'h2);
      wait_ev();
      rd(CSR_ADDR, 32'h0);
      rd(IST_ADDR, 32'h1);
      settle_irq(1'b1);
      wr(IEN_ADDR, 32'h0);
      settle_irq(1'b0);
      wr(ICLR_ADDR, 32'h1);
      rd(IST_ADDR, 32'h0);
      err_addr <= 32'hffffffff;
      $display("test abort done");
      repeat (4) @(posedge pclk);
      report_and_stop();
   end
endmodule
